// [logic/eeprom_pkg.sv]
// constants, field layouts and carrier types for the eeprom page access block
package eeprom_pkg;
  localparam int ARR_DEPTH = 256;
  localparam int PAGE_BYTES = 4;
  localparam int PAGE_COUNT = 64;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int APB_AW = 12;

  // register byte offsets
  localparam logic [APB_AW-1:0] OFS_CTRL = 12'h000;
  localparam logic [APB_AW-1:0] OFS_ADDR = 12'h004;
  localparam logic [APB_AW-1:0] OFS_DATA = 12'h008;
  localparam logic [APB_AW-1:0] OFS_RELOAD = 12'h00c;
  localparam logic [APB_AW-1:0] OFS_COUNT = 12'h010;
  localparam logic [APB_AW-1:0] OFS_STAT = 12'h014;
  localparam logic [APB_AW-1:0] OFS_MASK = 12'h018;

  // control register fields
  localparam int CTRL_MODE_LSB = 1;
  localparam int CTRL_EWP_BIT = 4;
  localparam int CTRL_RUN_BIT = 7;
  localparam int CTRL_BYTE_BIT = 8;

  // mode field encodings
  localparam logic [2:0] MODE_READ = 3'h0;
  localparam logic [2:0] MODE_INCR = 3'h2;
  localparam logic [1:0] MODE_WRPG_HI = 2'h1;
  localparam logic [2:0] MODE_ERWR = 3'h4;
  localparam logic [2:0] MODE_ERPG = 3'h7;

  // status / mask layout
  localparam int STAT_W = 2;
  localparam int STAT_UF_BIT = 0;
  localparam int STAT_DONE_BIT = 1;

  localparam logic [1:0] LATCH_LAST = 2'h3;
  localparam logic [ADDR_W-1:0] ADDR_RST = 8'h00;
  localparam logic [DATA_W-1:0] RELOAD_RST = 8'hff;
  localparam logic [DATA_W-1:0] BYTE_ERASED = 8'h00;

  // timing
  localparam int CLK_MHZ = 200;
  localparam int OP_TIME_MS = 5;
  localparam int OP_CYCLES_DEF = OP_TIME_MS * 1000 * CLK_MHZ;
  localparam int TICK_TIME_US = 20;
  localparam int TICK_CYCLES_DEF = TICK_TIME_US * CLK_MHZ;

  typedef struct packed {
    logic byte_only;
    logic run;
    logic erase_write_in_progress;
    logic [2:0] mode;
  } ctrl_s;

  typedef struct packed {
    logic [APB_AW-1:0] addr;
    logic write;
    logic [31:0] wdata;
  } apb_req_s;

  typedef enum logic {ST_IDLE, ST_BUSY} arr_state_e;
endpackage

// [logic/eeprom_page_access.sv]
// eeprom page access logic with reload down-counter, apb register slave
//
// Added by the designer: the register addresses and register access over APB.
`timescale 1ns/1ps
module eeprom_page_access #(
  parameter int unsigned OP_CYCLES = eeprom_pkg::OP_CYCLES_DEF,
  parameter int unsigned TICK_CYCLES = eeprom_pkg::TICK_CYCLES_DEF
) (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [eeprom_pkg::APB_AW-1:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  output logic irq_o
);
  import eeprom_pkg::*;

  localparam int OPW = $clog2(OP_CYCLES + 1);
  localparam int TW = $clog2(TICK_CYCLES + 1);
  localparam logic [OPW-1:0] OP_LOAD = OPW'(OP_CYCLES - 1);
  localparam logic [TW-1:0] TICK_LOAD = TW'(TICK_CYCLES - 1);

  apb_req_s req;
  ctrl_s ctrl_r;
  arr_state_e state_r;
  logic [DATA_W-1:0] mem_r [ARR_DEPTH];
  logic [DATA_W-1:0] latch_r [PAGE_BYTES];
  logic [ADDR_W-1:0] addr_r;
  logic [DATA_W-1:0] reload_r;
  logic [DATA_W-1:0] count_r;
  logic [STAT_W-1:0] stat_r;
  logic [STAT_W-1:0] mask_r;
  logic [OPW-1:0] op_cnt_r;
  logic [TW-1:0] tick_cnt_r;
  logic [2:0] op_mode_r;
  logic op_byte_r;
  logic [ADDR_W-1:0] op_addr_r;
  logic [31:0] prdata_r;
  logic pready_r;
  logic pslverr_r;
  logic irq_r;

  logic acc_first;
  logic acc_done;
  logic wr_done;
  logic rd_done;
  logic hit;
  logic [31:0] rd_val;
  logic start_ok;
  logic op_end;
  logic run_start;
  logic tick;
  logic uf_evt;
  logic [STAT_W-1:0] stat_set;
  logic [STAT_W-1:0] stat_clr;
  logic [2:0] wr_mode;
  logic busy;

  assign req = '{addr: paddr_i, write: pwrite_i, wdata: pwdata_i};
  // each access takes one wait state so read data can come from a flop
  assign acc_first = psel_i & penable_i & ~pready_r;
  assign acc_done = psel_i & penable_i & pready_r;
  assign wr_done = acc_done & req.write;
  assign rd_done = acc_done & ~req.write;
  assign busy = (state_r == ST_BUSY);
  assign wr_mode = req.wdata[CTRL_MODE_LSB +: 3];

  // only the four erase/write codes (2, 3, 4 and 7) may start a cycle
  assign start_ok = wr_done && (req.addr == OFS_CTRL) && req.wdata[CTRL_EWP_BIT] && !busy &&
                    ((wr_mode[2:1] == MODE_WRPG_HI) || (wr_mode == MODE_ERWR) ||
                     (wr_mode == MODE_ERPG));
  assign op_end = busy && (op_cnt_r == '0);
  assign run_start = start_ok ||
                     (wr_done && (req.addr == OFS_CTRL) && req.wdata[CTRL_RUN_BIT] &&
                      !ctrl_r.run);
  assign tick = (tick_cnt_r == '0);
  assign uf_evt = ctrl_r.run && tick && (count_r == '0) && !run_start;

  always_comb begin
    hit = 1'b1;
    rd_val = '0;
    if (req.addr == OFS_CTRL) begin
      rd_val = {23'h0, ctrl_r.byte_only, ctrl_r.run, mask_r[STAT_UF_BIT], stat_r[STAT_UF_BIT],
                ctrl_r.erase_write_in_progress, ctrl_r.mode, 1'b0};
    end else if (req.addr == OFS_ADDR) begin
      rd_val = {24'h0, addr_r};
    end else if (req.addr == OFS_DATA) begin
      rd_val = {24'h0, mem_r[addr_r]};
    end else if (req.addr == OFS_RELOAD) begin
      rd_val = {24'h0, reload_r};
    end else if (req.addr == OFS_COUNT) begin
      rd_val = {24'h0, count_r};
    end else if (req.addr == OFS_STAT) begin
      rd_val = {30'h0, stat_r};
    end else if (req.addr == OFS_MASK) begin
      rd_val = {30'h0, mask_r};
    end else begin
      hit = 1'b0;
    end
  end

  // apb answer
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pready_r <= 1'b0;
      prdata_r <= '0;
      pslverr_r <= 1'b0;
    end else if (acc_first) begin
      pready_r <= 1'b1;
      prdata_r <= req.write ? 32'h0 : rd_val;
      pslverr_r <= ~hit;
    end else begin
      pready_r <= 1'b0;
      prdata_r <= '0;
      pslverr_r <= 1'b0;
    end
  end

  // control register
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ctrl_r <= '0;
    end else begin
      if (wr_done && (req.addr == OFS_CTRL)) begin
        ctrl_r.byte_only <= req.wdata[CTRL_BYTE_BIT];
        ctrl_r.mode <= wr_mode;
        ctrl_r.run <= req.wdata[CTRL_RUN_BIT] | start_ok;
      end
      if (op_end) begin
        ctrl_r.erase_write_in_progress <= 1'b0;
      end else if (start_ok) begin
        ctrl_r.erase_write_in_progress <= 1'b1;
      end
    end
  end

  // array cycle sequencer: operands are captured so later writes cannot disturb a cycle
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_r <= ST_IDLE;
      op_cnt_r <= '0;
      op_mode_r <= MODE_READ;
      op_byte_r <= 1'b0;
      op_addr_r <= ADDR_RST;
    end else begin
      case (state_r)
        ST_IDLE: begin
          if (start_ok) begin
            state_r <= ST_BUSY;
            op_cnt_r <= OP_LOAD;
            op_mode_r <= wr_mode;
            op_byte_r <= req.wdata[CTRL_BYTE_BIT];
            op_addr_r <= addr_r;
          end
        end
        ST_BUSY: begin
          if (op_end) begin
            state_r <= ST_IDLE;
          end else begin
            op_cnt_r <= op_cnt_r - 1'b1;
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // array: no reset, contents are meant to survive (no battery needed)
  always_ff @(posedge sys_clk_i) begin
    for (int i = 0; i < PAGE_BYTES; i++) begin
      if (op_end && (!op_byte_r || (op_addr_r[1:0] == 2'(i)))) begin
        if (op_mode_r == MODE_ERPG) begin
          mem_r[{op_addr_r[ADDR_W-1:2], 2'(i)}] <= BYTE_ERASED;
        end else if (op_mode_r == MODE_ERWR) begin
          mem_r[{op_addr_r[ADDR_W-1:2], 2'(i)}] <= latch_r[i];
        end else begin
          mem_r[{op_addr_r[ADDR_W-1:2], 2'(i)}] <=
            mem_r[{op_addr_r[ADDR_W-1:2], 2'(i)}] | latch_r[i];
        end
      end
    end
  end

  // page latches; writes during a cycle are dropped to keep the cycle's data stable
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      for (int i = 0; i < PAGE_BYTES; i++) begin
        latch_r[i] <= BYTE_ERASED;
      end
    end else if (wr_done && (req.addr == OFS_DATA) && !busy) begin
      latch_r[addr_r[1:0]] <= req.wdata[DATA_W-1:0];
    end
  end

  // address pointer
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      addr_r <= ADDR_RST;
    end else if (wr_done && (req.addr == OFS_ADDR)) begin
      addr_r <= req.wdata[ADDR_W-1:0];
    end else if (op_end && (op_mode_r != MODE_ERPG)) begin
      if (op_byte_r) begin
        addr_r <= op_addr_r + 1'b1;
      end else begin
        addr_r <= {op_addr_r[ADDR_W-1:2] + 1'b1, 2'b00};
      end
    end else if (rd_done && (req.addr == OFS_DATA)) begin
      addr_r <= addr_r + 1'b1;
    end else if (wr_done && (req.addr == OFS_DATA) && !busy && (ctrl_r.mode == MODE_INCR) &&
                 !ctrl_r.erase_write_in_progress && (addr_r[1:0] != LATCH_LAST)) begin
      addr_r[1:0] <= addr_r[1:0] + 1'b1;
    end
  end

  // counter prescaler, free running so ticks stay evenly spaced
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      tick_cnt_r <= TICK_LOAD;
    end else if (tick) begin
      tick_cnt_r <= TICK_LOAD;
    end else begin
      tick_cnt_r <= tick_cnt_r - 1'b1;
    end
  end

  // reload down-counter for general use; array timing uses its own op_cnt_r counter
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      reload_r <= RELOAD_RST;
      count_r <= RELOAD_RST;
    end else begin
      if (wr_done && (req.addr == OFS_RELOAD)) begin
        reload_r <= req.wdata[DATA_W-1:0];
      end
      if (run_start) begin
        count_r <= reload_r;
      end else if (ctrl_r.run && tick) begin
        count_r <= (count_r == '0) ? reload_r : count_r - 1'b1;
      end
    end
  end

  // sticky status, write one to clear; a new event wins over its clear
  assign stat_set = {op_end, uf_evt};
  assign stat_clr = (wr_done && (req.addr == OFS_STAT)) ? req.wdata[STAT_W-1:0] : '0;

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      stat_r <= '0;
      mask_r <= '0;
      irq_r <= 1'b0;
    end else begin
      stat_r <= (stat_r & ~stat_clr) | stat_set;
      if (wr_done && (req.addr == OFS_MASK)) begin
        mask_r <= req.wdata[STAT_W-1:0];
      end
      irq_r <= |(stat_r & mask_r);
    end
  end

  assign prdata_o = prdata_r;
  assign pready_o = pready_r;
  assign pslverr_o = pslverr_r;
  assign irq_o = irq_r;

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);

  logic [ADDR_W-1:0] pg_base;
  assign pg_base = {op_addr_r[ADDR_W-1:2], 2'b00};

  sequence s_start;
    start_ok;
  endsequence
  sequence s_finish;
    op_end && !op_byte_r;
  endsequence

  property p_start_flags;
    s_start |=> ctrl_r.erase_write_in_progress && ctrl_r.run && busy && (op_cnt_r == OP_LOAD);
  endproperty
  a_start_flags: assert property (p_start_flags)
    else $error("start did not raise progress flag and counter");

  property p_flag_clears;
    s_finish or (op_end && op_byte_r) |=> !ctrl_r.erase_write_in_progress && stat_r[STAT_DONE_BIT];
  endproperty
  a_flag_clears: assert property (p_flag_clears)
    else $error("progress flag not cleared at cycle end");

  property p_cycle_len;
    busy && (op_cnt_r == OP_LOAD) |-> !op_end ##1 (busy && ctrl_r.erase_write_in_progress) [*2];
  endproperty
  a_cycle_len: assert property (p_cycle_len)
    else $error("array cycle ended too early");

  property p_or_write;
    s_finish and (op_mode_r[2:1] == MODE_WRPG_HI)
      |=> mem_r[$past(pg_base)] == ($past(mem_r[pg_base]) | $past(latch_r[0]));
  endproperty
  a_or_write: assert property (p_or_write)
    else $error("page write did not OR into stored byte");

  property p_erase_zero;
    s_finish and (op_mode_r == MODE_ERPG)
      |=> (mem_r[$past(pg_base) + 8'h3] == BYTE_ERASED) && (addr_r == $past(addr_r));
  endproperty
  a_erase_zero: assert property (p_erase_zero)
    else $error("erase left bits set or moved the pointer");

  property p_read_data;
    acc_first && !req.write && (req.addr == OFS_DATA)
      |=> pready_o && (prdata_o == {24'h0, $past(mem_r[addr_r])});
  endproperty
  a_read_data: assert property (p_read_data)
    else $error("data window read returned wrong byte");

  property p_read_incr;
    rd_done && (req.addr == OFS_DATA) && !op_end |=> addr_r == $past(addr_r) + 8'h1;
  endproperty
  a_read_incr: assert property (p_read_incr)
    else $error("pointer did not advance after read");

  property p_underflow;
    uf_evt |=> stat_r[STAT_UF_BIT] && (count_r == $past(reload_r));
  endproperty
  a_underflow: assert property (p_underflow)
    else $error("underflow did not reload and flag");

  property p_hold;
    !ctrl_r.run && !run_start |=> $stable(count_r);
  endproperty
  a_hold: assert property (p_hold)
    else $error("stopped counter changed");

  property p_latch_load;
    wr_done && (req.addr == OFS_DATA) && !busy
      |=> latch_r[$past(addr_r[1:0])] == $past(req.wdata[DATA_W-1:0]);
  endproperty
  a_latch_load: assert property (p_latch_load)
    else $error("data write did not load the selected latch");
endmodule // eeprom_page_access

// [verif/tb_top.sv]
// self-checking testbench for the eeprom page access block
`timescale 1ns/1ps
module tb_top;
  import eeprom_pkg::*;
  // short cycle and tick so the 5 ms cycle fits in simulation
  localparam int OPC = 40;
  localparam int TKC = 4;
  typedef struct packed {
    logic [APB_AW-1:0] a;
    logic w;
    logic [31:0] d;
    logic [31:0] e;
    logic er;
  } row_s;
  localparam row_s ROWS[13] = '{
    '{OFS_CTRL, 1'b0, 32'h0, 32'h0, 1'b0},
    '{OFS_ADDR, 1'b0, 32'h0, 32'h0, 1'b0},
    '{OFS_RELOAD, 1'b0, 32'h0, 32'hff, 1'b0},
    '{OFS_COUNT, 1'b0, 32'h0, 32'hff, 1'b0},
    '{OFS_STAT, 1'b0, 32'h0, 32'h0, 1'b0},
    '{OFS_MASK, 1'b0, 32'h0, 32'h0, 1'b0},
    '{OFS_RELOAD, 1'b1, 32'h3c, 32'h0, 1'b0},
    '{OFS_RELOAD, 1'b0, 32'h0, 32'h3c, 1'b0},
    '{OFS_COUNT, 1'b1, 32'h12, 32'h0, 1'b0},
    '{OFS_COUNT, 1'b0, 32'h0, 32'hff, 1'b0},
    '{OFS_ADDR, 1'b1, 32'ha7, 32'h0, 1'b0},
    '{OFS_ADDR, 1'b0, 32'h0, 32'ha7, 1'b0},
    '{12'h01c, 1'b0, 32'h0, 32'h0, 1'b1}
  };
  logic sys_clk_i, rst_i, psel_i, penable_i, pwrite_i;
  logic [APB_AW-1:0] paddr_i;
  logic [31:0] pwdata_i, prdata_o, rd_v, hold_v;
  logic pready_o, pslverr_o, irq_o, err_v;
  int bad_count = 0;
  int comparisons = 0;
  int cyc = 0;
  int t0;

  eeprom_page_access #(.OP_CYCLES(OPC), .TICK_CYCLES(TKC)) DUT (
    .sys_clk_i(sys_clk_i), .rst_i(rst_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o), .irq_o(irq_o));

  initial begin
    sys_clk_i = 1'b0;
    forever #2.5 sys_clk_i = ~sys_clk_i;
  end
  always @(posedge sys_clk_i) cyc <= cyc + 1;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one apb transfer; ready, data and error are taken at the rising edge that sees ready high
  task automatic apb(input logic [APB_AW-1:0] a, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge sys_clk_i);
    psel_i <= 1'b1;
    paddr_i <= a;
    pwrite_i <= w;
    pwdata_i <= d;
    @(posedge sys_clk_i);
    penable_i <= 1'b1;
    do begin
      @(posedge sys_clk_i);
      n++;
    end while (pready_o !== 1'b1 && n < 20);
    if (pready_o !== 1'b1) chk(32'h0, 32'h1);
    rd_v = prdata_o;
    err_v = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask

  task automatic wr(input logic [APB_AW-1:0] a, input logic [31:0] d);
    apb(a, 1'b1, d);
  endtask

  task automatic rd(input logic [APB_AW-1:0] a, input logic [31:0] e, input logic [31:0] m);
    apb(a, 1'b0, 32'h0);
    chk(rd_v & m, e);
  endtask

  task automatic wait_idle;
    int n;
    n = 0;
    do begin
      apb(OFS_CTRL, 1'b0, 32'h0);
      n++;
    end while (rd_v[CTRL_EWP_BIT] !== 1'b0 && n < 40);
    chk({31'h0, rd_v[CTRL_EWP_BIT]}, 32'h0);
    chk(((cyc - t0) >= OPC + 1 && (cyc - t0) <= OPC + 6) ? 32'h1 : 32'h0, 32'h1);
  endtask

  task automatic op(input logic [31:0] code);
    wr(OFS_CTRL, code);
    t0 = cyc;
    rd(OFS_CTRL, 32'h10, 32'h10);
    wait_idle();
  endtask

  // latches are written in increment mode from latch 0
  task automatic fill(input logic [31:0] w);
    wr(OFS_CTRL, 32'h4);
    wr(OFS_ADDR, 32'h0);
    for (int i = 0; i < 4; i++) wr(OFS_DATA, {24'h0, w[8*i +: 8]});
  endtask

  task automatic page_is(input logic [31:0] w);
    wr(OFS_ADDR, 32'h0);
    for (int i = 0; i < 4; i++) rd(OFS_DATA, {24'h0, w[8*i +: 8]}, 32'hffffffff);
  endtask

  task automatic final_report;
    $display("comparisons=%0d bad_count=%0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (30000) @(posedge sys_clk_i);
    bad_count++;
    final_report();
  end

  initial begin
    rst_i = 1'b1;
    psel_i = 1'b0;
    penable_i = 1'b0;
    pwrite_i = 1'b0;
    paddr_i = '0;
    pwdata_i = '0;
    repeat (5) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    foreach (ROWS[i]) begin
      apb(ROWS[i].a, ROWS[i].w, ROWS[i].d);
      if (!ROWS[i].w) chk(rd_v, ROWS[i].e);
      chk({31'h0, err_v}, {31'h0, ROWS[i].er});
    end
    $display("register table done");
    wr(OFS_ADDR, 32'h0);
    op(32'h1e);
    rd(OFS_ADDR, 32'h0, 32'hff);
    rd(OFS_STAT, 32'h2, 32'h2);
    page_is(32'h0);
    rd(OFS_ADDR, 32'h4, 32'hff);
    $display("erase page done");
    fill(32'h44332211);
    rd(OFS_ADDR, 32'h3, 32'hff);
    op(32'h14);
    rd(OFS_ADDR, 32'h4, 32'hff);
    page_is(32'h44332211);
    fill(32'h0100f00f);
    op(32'h16);
    page_is(32'h4533f21f);
    $display("write page done");
    fill(32'h5a00a581);
    op(32'h18);
    page_is(32'h5a00a581);
    $display("erase write page done");
    wr(OFS_CTRL, 32'h0);
    wr(OFS_ADDR, 32'h2);
    wr(OFS_DATA, 32'h3c);
    wr(OFS_ADDR, 32'h2);
    wr(OFS_CTRL, 32'h118);
    t0 = cyc;
    // a latch write during the cycle must not reach the array
    wr(OFS_DATA, 32'hff);
    wait_idle();
    rd(OFS_ADDR, 32'h3, 32'hff);
    page_is(32'h5a3ca581);
    wr(OFS_ADDR, 32'hff);
    wr(OFS_DATA, 32'h77);
    op(32'h118);
    rd(OFS_ADDR, 32'h0, 32'hff);
    wr(OFS_ADDR, 32'hff);
    rd(OFS_DATA, 32'h77, 32'hff);
    rd(OFS_ADDR, 32'h0, 32'hff);
    $display("byte op and wrap done");
    // a code outside the erase/write set must not start a cycle
    wr(OFS_CTRL, 32'h12);
    rd(OFS_CTRL, 32'h0, 32'h10);
    chk({31'h0, irq_o}, 32'h0);
    wr(OFS_CTRL, 32'h0);
    wr(OFS_STAT, 32'h3);
    rd(OFS_STAT, 32'h0, 32'h3);
    wr(OFS_RELOAD, 32'h2);
    wr(OFS_MASK, 32'h1);
    wr(OFS_CTRL, 32'h80);
    t0 = 0;
    while (irq_o !== 1'b1 && t0 < 200) begin
      t0++;
      @(negedge sys_clk_i);
    end
    chk({31'h0, irq_o}, 32'h1);
    rd(OFS_CTRL, 32'h20, 32'h20);
    wr(OFS_CTRL, 32'h0);
    apb(OFS_COUNT, 1'b0, 32'h0);
    hold_v = rd_v;
    repeat (20) @(posedge sys_clk_i);
    rd(OFS_COUNT, hold_v, 32'hff);
    wr(OFS_STAT, 32'h1);
    repeat (2) @(posedge sys_clk_i);
    chk({31'h0, irq_o}, 32'h0);
    $display("counter and interrupt done");
    rst_i <= 1'b1;
    @(posedge sys_clk_i);
    rst_i <= 1'b0;
    rd(OFS_RELOAD, 32'hff, 32'hffffffff);
    rd(OFS_ADDR, 32'h0, 32'hffffffff);
    $display("second reset done");
    final_report();
  end
endmodule // tb_top
